/* File: hw/voice_switch_mode_decision.sv */
`timescale 1ns/1ps
`default_nettype none
module voice_switch_mode_decision
  import vsw_pkg::*;
#(
  parameter int unsigned FAST_STEP = FAST_STEP_CYC,
  parameter int unsigned SLOW_STEP = SLOW_STEP_CYC
) (
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output wire logic       sda_o,
  output wire logic       sda_oe_n_o,
  input  wire logic       cmp_tx_vs_calc_rx_i,
  input  wire logic       cmp_calc_tx_vs_rx_i,
  input  wire logic       tx_speech_flag_i,
  input  wire logic       rx_speech_flag_i,
  input  wire logic       dial_tone_i,
  input  wire logic       log_tx_gt_rx_i,
  output var  logic [7:0] diff_ctrl_tx_o,
  output var  logic [7:0] diff_ctrl_rx_o,
  output wire logic [1:0] mode_o,
  output wire logic       four_point_o,
  output wire logic [4:0] rx_calc_log_adjust_o,
  output wire logic [4:0] tx_calc_log_adjust_o,
  output wire logic [5:0] afs_gain_o
);
  logic [SYNC_W-1:0] meta_reg;
  logic [SYNC_W-1:0] sync_reg;
  logic              scl_d_reg;
  logic              sda_d_reg;
  logic              scl_s;
  logic              sda_s;
  logic              start_det;
  logic              stop_det;
  logic              scl_rise;
  logic              scl_fall;
  ser_state_t        ser_state_reg;
  logic [2:0]        bit_cnt_reg;
  logic [7:0]        shift_reg;
  logic [7:0]        shout_reg;
  logic [4:0]        index_reg;
  logic              is_read_reg;
  logic              sda_drv_reg;
  logic [7:0]        rx_byte;
  logic [4:0]        rx_field;
  logic              last_bit;
  logic              wr_en;
  logic [7:0]        rd_data;
  logic [7:0]        afs_reg;
  logic [7:0]        rth_reg;
  logic [7:0]        rxadj_reg;
  logic [7:0]        txadj_reg;
  logic              four_point;
  logic              t1;
  logic              t2;
  logic              s3;
  logic              s4;
  logic              dial;
  logic              log_tx;
  mode_t             mode_reg;
  mode_t             mode_next;
  ramp_if            rif ();

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  // ==================================================================
  // input synchronisers
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      // bus lanes reset idle-high so no false edge follows reset
      meta_reg           <= '0;
      sync_reg           <= '0;
      meta_reg[SYNC_SCL] <= 1'b1;
      meta_reg[SYNC_SDA] <= 1'b1;
      sync_reg[SYNC_SCL] <= 1'b1;
      sync_reg[SYNC_SDA] <= 1'b1;
    end else begin
      meta_reg <= {log_tx_gt_rx_i, dial_tone_i, rx_speech_flag_i, tx_speech_flag_i,
                   cmp_calc_tx_vs_rx_i, cmp_tx_vs_calc_rx_i, sda_i, scl_i};
      sync_reg <= meta_reg;
    end
  end

  assign scl_s  = sync_reg[SYNC_SCL];
  assign sda_s  = sync_reg[SYNC_SDA];
  assign t1     = sync_reg[SYNC_TXC];
  assign t2     = sync_reg[SYNC_RXC];
  assign s3     = sync_reg[SYNC_SP_TX];
  assign s4     = sync_reg[SYNC_SP_RX];
  assign dial   = sync_reg[SYNC_DIAL];
  assign log_tx = sync_reg[SYNC_LOG];

  // ==================================================================
  // serial bus slave
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  assign scl_rise  = scl_s & ~scl_d_reg;
  assign scl_fall  = ~scl_s & scl_d_reg;
  assign rx_byte   = {shift_reg[BYTE_MSB-1:0], sda_s};
  assign rx_field  = rx_byte[ADJ_MSB:ADJ_LSB];
  assign last_bit  = (bit_cnt_reg == BYTE_LAST);

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ser_state_reg <= SER_IDLE;
      bit_cnt_reg   <= 3'h0;
      shift_reg     <= 8'h00;
      shout_reg     <= 8'h00;
      index_reg     <= 5'h00;
      is_read_reg   <= 1'b0;
      sda_drv_reg   <= 1'b0;
    end else if (start_det) begin
      ser_state_reg <= SER_INDEX;
      bit_cnt_reg   <= 3'h0;
      sda_drv_reg   <= 1'b0;
    end else if (stop_det) begin
      ser_state_reg <= SER_IDLE;
      sda_drv_reg   <= 1'b0;
    end else begin
      case (ser_state_reg)
        SER_INDEX: begin
          if (scl_rise) begin
            shift_reg   <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (last_bit) begin
              index_reg     <= rx_byte[IDX_MSB:0];
              is_read_reg   <= rx_byte[READ_FLAG_BIT];
              ser_state_reg <= SER_ACK1;
            end
          end
        end
        SER_ACK1: begin
          if (scl_fall && !sda_drv_reg) begin
            sda_drv_reg <= 1'b1;
          end else if (scl_fall) begin
            bit_cnt_reg   <= 3'h0;
            shout_reg     <= rd_data;
            sda_drv_reg   <= is_read_reg & ~rd_data[BYTE_MSB];
            ser_state_reg <= SER_DATA;
          end
        end
        SER_DATA: begin
          if (scl_rise) begin
            shift_reg   <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (last_bit) begin
              ser_state_reg <= SER_ACK2;
            end
          end else if (scl_fall && is_read_reg) begin
            shout_reg   <= {shout_reg[BYTE_MSB-1:0], 1'b0};
            sda_drv_reg <= ~shout_reg[BYTE_MSB-1];
          end
        end
        SER_ACK2: begin
          if (scl_fall && (is_read_reg || sda_drv_reg)) begin
            sda_drv_reg   <= 1'b0;
            ser_state_reg <= SER_IDLE;
          end else if (scl_fall) begin
            sda_drv_reg <= 1'b1;
          end
        end
        default: begin
          sda_drv_reg <= 1'b0;
        end
      endcase
    end
  end

  assign sda_o      = 1'b0;
  assign sda_oe_n_o = ~sda_drv_reg;
  assign wr_en      = (ser_state_reg == SER_DATA) & ~is_read_reg & scl_rise & last_bit;

  // ==================================================================
  // configuration registers
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      afs_reg   <= REG_RESET;
      rth_reg   <= REG_RESET;
      rxadj_reg <= REG_RESET;
      txadj_reg <= REG_RESET;
    end else if (wr_en) begin
      if (index_reg == REG_AFS_IDX) begin
        afs_reg <= rx_byte & AFS_MASK;
      end else if (index_reg == REG_RTH_IDX) begin
        rth_reg <= rx_byte;
      end else if (index_reg == REG_RXADJ_IDX) begin
        rxadj_reg <= rx_byte & RXADJ_MASK;
      end else if (index_reg == REG_TXADJ_IDX) begin
        txadj_reg <= rx_byte & TXADJ_MASK;
      end
    end
  end

  always_comb begin
    if (index_reg == REG_AFS_IDX) begin
      rd_data = afs_reg;
    end else if (index_reg == REG_RTH_IDX) begin
      rd_data = rth_reg;
    end else if (index_reg == REG_RXADJ_IDX) begin
      rd_data = rxadj_reg;
    end else if (index_reg == REG_TXADJ_IDX) begin
      rd_data = txadj_reg;
    end else if (index_reg == REG_STATUS_IDX) begin
      rd_data = {5'h00, four_point, mode_reg};
    end else begin
      rd_data = 8'h00;
    end
  end

  assign four_point           = afs_reg[TOPO_BIT];
  assign four_point_o         = four_point;
  assign afs_gain_o           = afs_reg[AFS_GAIN_MSB:0];
  assign rx_calc_log_adjust_o = rxadj_reg[ADJ_MSB:ADJ_LSB];
  assign tx_calc_log_adjust_o = txadj_reg[ADJ_MSB:ADJ_LSB];

  // ==================================================================
  // mode decision
  always_comb begin
    mode_next = MODE_IDLE;
    if (!four_point) begin
      mode_next = log_tx ? MODE_TX : MODE_RX;
    end else if (t1 && t2) begin
      mode_next = s3 ? MODE_TX : MODE_IDLE;
    end else if (!t1 && !t2) begin
      mode_next = s4 ? MODE_RX : MODE_IDLE;
    end else begin
      mode_next = (s3 || s4) ? MODE_CHG : MODE_IDLE;
    end
    if (four_point && mode_next == MODE_IDLE && dial) begin
      mode_next = MODE_RX;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_reg <= MODE_IDLE;
    end else begin
      mode_reg <= mode_next;
    end
  end

  assign mode_o = mode_reg;

  // ==================================================================
  // attenuator control
  always_comb begin
    rif.fast   = 1'b1;
    rif.target = POS_MID;
    if (!four_point) begin
      rif.target = log_tx ? POS_MAX : POS_MIN;
    end else begin
      case (mode_reg)
        MODE_TX:  rif.target = POS_MAX;
        MODE_RX:  rif.target = POS_MIN;
        MODE_CHG: rif.target = POS_MID;
        default: begin
          rif.target = POS_MID;
          rif.fast   = 1'b0;
        end
      endcase
    end
  end

  atten_ramp #(
    .FAST_STEP (FAST_STEP),
    .SLOW_STEP (SLOW_STEP)
  ) u_ramp (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .rif    (rif)
  );

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      diff_ctrl_tx_o <= POS_MID;
      diff_ctrl_rx_o <= POS_MID;
    end else begin
      diff_ctrl_tx_o <= POS_MAX - rif.pos;
      diff_ctrl_rx_o <= rif.pos;
    end
  end

  // ==================================================================
  // checks
  sequence s_tx_cond;
    four_point && t1 && t2 && s3;
  endsequence
  sequence s_idle_cond;
    four_point && ((t1 && t2 && !s3) || (!t1 && !t2 && !s4) || (t1 != t2 && !s3 && !s4));
  endsequence
  sequence s_rxadj_write;
    wr_en && index_reg == REG_RXADJ_IDX;
  endsequence

  chk_tx_decode: assert property (s_tx_cond |=> mode_reg == MODE_TX)
    else $error("transmit decode missed");
  chk_rx_decode: assert property (four_point && !t1 && !t2 && s4 |=> mode_reg == MODE_RX)
    else $error("receive decode missed");
  chk_change_mode: assert property (four_point && t1 != t2 && (s3 || s4) |=> mode_reg == MODE_CHG)
    else $error("change mode decode missed");
  chk_idle_decode: assert property (s_idle_cond ##0 !dial |=> mode_reg == MODE_IDLE)
    else $error("idle decode missed");
  chk_dial_block: assert property (s_idle_cond ##0 dial |=> mode_reg == MODE_RX)
    else $error("dial tone did not block idle");
  chk_two_point: assert property (!four_point |-> rif.fast && rif.target == (log_tx ? POS_MAX : POS_MIN))
    else $error("two-point target wrong");
  chk_loop_gain: assert property (diff_ctrl_tx_o + diff_ctrl_rx_o == POS_MAX)
    else $error("loop gain sum not constant");
  chk_idle_slow: assert property (four_point && mode_reg == MODE_IDLE |-> !rif.fast && rif.target == POS_MID)
    else $error("idle not slow half attenuation");
  chk_rxadj_field: assert property (s_rxadj_write |=> rx_calc_log_adjust_o == $past(rx_field))
    else $error("rx adjust field not stored");
  chk_txadj_field: assert property (wr_en && index_reg == REG_TXADJ_IDX |=> tx_calc_log_adjust_o == $past(rx_field))
    else $error("tx adjust field not stored");
  chk_ctrl_follow: assert property ($changed(rif.pos) |=> diff_ctrl_rx_o == $past(rif.pos))
    else $error("control pair does not follow ramp");
endmodule
`default_nettype wire

/* File: inc/vsw_pkg.sv */
`default_nettype none
package vsw_pkg;
  // ==================================================================
  // timing
  localparam int unsigned CLK_FREQ_HZ     = 200_000_000;
  localparam int unsigned FAST_SWITCH_MS  = 30;
  localparam real         SLOW_SWITCH_S   = 1.5;
  localparam int unsigned FAST_SWITCH_CYC = FAST_SWITCH_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned SLOW_SWITCH_CYC = int'(SLOW_SWITCH_S * CLK_FREQ_HZ);

  // ==================================================================
  // attenuator control positions (0 = receive open, max = transmit open)
  localparam logic [7:0]  POS_MIN       = 8'h00;
  localparam logic [7:0]  POS_MID       = 8'h7F;
  localparam logic [7:0]  POS_MAX       = 8'hFE;
  localparam int unsigned FAST_STEP_CYC = FAST_SWITCH_CYC / int'(POS_MAX);
  localparam int unsigned SLOW_STEP_CYC = SLOW_SWITCH_CYC / int'(POS_MAX);

  // ==================================================================
  // serial register indices and fields
  localparam logic [4:0] REG_AFS_IDX    = 5'h09;
  localparam logic [4:0] REG_RTH_IDX    = 5'h0D;
  localparam logic [4:0] REG_RXADJ_IDX  = 5'h0E;
  localparam logic [4:0] REG_TXADJ_IDX  = 5'h0F;
  localparam logic [4:0] REG_STATUS_IDX = 5'h10;
  localparam logic [7:0] REG_RESET      = 8'h00;
  localparam logic [7:0] AFS_MASK       = 8'h7F;
  localparam logic [7:0] RXADJ_MASK     = 8'hFB;
  localparam logic [7:0] TXADJ_MASK     = 8'hF8;
  localparam int         TOPO_BIT       = 6;
  localparam int         AFS_GAIN_MSB   = 5;
  localparam int         ADJ_LSB        = 3;
  localparam int         ADJ_MSB        = 7;
  localparam int         BYTE_MSB       = 7;
  localparam int         IDX_MSB        = 4;
  localparam int         READ_FLAG_BIT  = 7;
  localparam logic [2:0] BYTE_LAST      = 3'h7;

  // ==================================================================
  // synchroniser lanes
  localparam int SYNC_SCL   = 0;
  localparam int SYNC_SDA   = 1;
  localparam int SYNC_TXC   = 2;
  localparam int SYNC_RXC   = 3;
  localparam int SYNC_SP_TX = 4;
  localparam int SYNC_SP_RX = 5;
  localparam int SYNC_DIAL  = 6;
  localparam int SYNC_LOG   = 7;
  localparam int SYNC_W     = 8;

  typedef enum logic [1:0] {MODE_IDLE, MODE_TX, MODE_RX, MODE_CHG} mode_t;
  typedef enum logic [2:0] {SER_IDLE, SER_INDEX, SER_ACK1, SER_DATA, SER_ACK2} ser_state_t;
endpackage
`default_nettype wire

/* File: inc/ramp_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ramp_if;
  logic [7:0] target;
  logic       fast;
  logic [7:0] pos;
  modport ctl  (output target, output fast, input pos);
  modport ramp (input target, input fast, output pos);
endinterface
`default_nettype wire

/* File: hw/atten_ramp.sv */
`timescale 1ns/1ps
`default_nettype none
module atten_ramp
  import vsw_pkg::*;
#(
  parameter int unsigned FAST_STEP = FAST_STEP_CYC,
  parameter int unsigned SLOW_STEP = SLOW_STEP_CYC
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  ramp_if.ramp     rif
);
  logic [31:0] tick_reg;
  logic [31:0] period;
  logic [7:0]  pos_reg;
  logic        step;

  // ==================================================================
  // step timer
  assign period = rif.fast ? FAST_STEP : SLOW_STEP;
  assign step   = (tick_reg >= period - 32'h1);

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_reg <= 32'h0;
    end else if (step || pos_reg == rif.target) begin
      tick_reg <= 32'h0;
    end else begin
      tick_reg <= tick_reg + 32'h1;
    end
  end

  // ==================================================================
  // position walks one step toward target
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pos_reg <= POS_MID;
    end else if (step && pos_reg < rif.target) begin
      pos_reg <= pos_reg + 8'h1;
    end else if (step && pos_reg > rif.target) begin
      pos_reg <= pos_reg - 8'h1;
    end
  end

  assign rif.pos = pos_reg;

  chk_step_size: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $changed(pos_reg) |-> (pos_reg == $past(pos_reg) + 8'h1 || pos_reg == $past(pos_reg) - 8'h1))
    else $error("ramp moved more than one step");
  chk_step_gap: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $changed(pos_reg) |=> $stable(pos_reg))
    else $error("ramp stepped on consecutive cycles");
endmodule
`default_nettype wire

/* File: dv/vsw_analog_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==================================================================
// level detectors, noise monitors, dial-tone comparator
module vsw_analog_model (
  input  wire logic [7:0] tx_lvl_i,
  input  wire logic [7:0] rx_lvl_i,
  input  wire logic [7:0] ctx_lvl_i,
  input  wire logic [7:0] crx_lvl_i,
  input  wire logic [4:0] tx_adj_i,
  input  wire logic [4:0] rx_adj_i,
  input  wire logic       tx_burst_i,
  input  wire logic       rx_burst_i,
  input  wire logic       tone_i,
  output wire logic       cmp_tx_vs_calc_rx_o,
  output wire logic       cmp_calc_tx_vs_rx_o,
  output wire logic       tx_speech_flag_o,
  output wire logic       rx_speech_flag_o,
  output wire logic       dial_tone_o,
  output wire logic       log_tx_gt_rx_o
);
  assign cmp_tx_vs_calc_rx_o = {1'b0, tx_lvl_i} > ({1'b0, crx_lvl_i} + {4'h0, rx_adj_i});
  assign cmp_calc_tx_vs_rx_o = ({1'b0, ctx_lvl_i} + {4'h0, tx_adj_i}) > {1'b0, rx_lvl_i};
  // bursty level reads as speech, steady level as noise
  assign tx_speech_flag_o    = tx_burst_i;
  assign rx_speech_flag_o    = rx_burst_i;
  assign dial_tone_o         = tone_i;
  assign log_tx_gt_rx_o      = tx_lvl_i > rx_lvl_i;
endmodule
`default_nettype wire

/* File: dv/voice_switch_mode_decision_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module voice_switch_mode_decision_tb;
  import vsw_pkg::*;
  localparam int FAST = 4;
  localparam int SLOW = 16;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       scl_drv = 1'b1;
  logic       sda_drv = 1'b1;
  logic [7:0] tx_lvl = 8'h80;
  logic [7:0] rx_lvl = 8'h80;
  logic [7:0] ctx_lvl = 8'h80;
  logic [7:0] crx_lvl = 8'h80;
  logic       tx_burst = 1'b0;
  logic       rx_burst = 1'b0;
  logic       tone = 1'b0;
  wire logic  sda_o, sda_oe_n_o, tx_vs_crx, ctx_vs_rx, s3, s4, dial, lgt, four_point_o;
  wire logic  sda_bus;
  logic [7:0] diff_ctrl_tx_o, diff_ctrl_rx_o;
  wire logic [1:0] mode_o;
  wire logic [4:0] rx_adj, tx_adj;
  wire logic [5:0] afs_gain_o;
  int         fails = 0;
  int         checks_done = 0;

  always #2.5 clk = ~clk;
  // open-drain data line with pull-up
  assign sda_bus = sda_drv & (sda_oe_n_o ? 1'b1 : sda_o);

  voice_switch_mode_decision #(.FAST_STEP(FAST), .SLOW_STEP(SLOW)) uut (
    .mclk_i(clk), .rstn_i(rst_n), .scl_i(scl_drv), .sda_i(sda_bus), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .cmp_tx_vs_calc_rx_i(tx_vs_crx), .cmp_calc_tx_vs_rx_i(ctx_vs_rx),
    .tx_speech_flag_i(s3), .rx_speech_flag_i(s4), .dial_tone_i(dial),
    .log_tx_gt_rx_i(lgt), .diff_ctrl_tx_o(diff_ctrl_tx_o), .diff_ctrl_rx_o(diff_ctrl_rx_o),
    .mode_o(mode_o), .four_point_o(four_point_o), .rx_calc_log_adjust_o(rx_adj),
    .tx_calc_log_adjust_o(tx_adj), .afs_gain_o(afs_gain_o));

  vsw_analog_model model (
    .tx_lvl_i(tx_lvl), .rx_lvl_i(rx_lvl), .ctx_lvl_i(ctx_lvl), .crx_lvl_i(crx_lvl),
    .tx_adj_i(tx_adj), .rx_adj_i(rx_adj), .tx_burst_i(tx_burst), .rx_burst_i(rx_burst),
    .tone_i(tone), .cmp_tx_vs_calc_rx_o(tx_vs_crx), .cmp_calc_tx_vs_rx_o(ctx_vs_rx),
    .tx_speech_flag_o(s3), .rx_speech_flag_o(s4), .dial_tone_o(dial), .log_tx_gt_rx_o(lgt));

  // ==================================================================
  // common tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic put_bit(input logic b);
    cyc(2);
    sda_drv = b;
    cyc(8);
    scl_drv = 1'b1;
    cyc(8);
    scl_drv = 1'b0;
  endtask

  task automatic get_bit(output logic v);
    cyc(2);
    sda_drv = 1'b1;
    cyc(8);
    scl_drv = 1'b1;
    cyc(8);
    v = sda_bus;
    scl_drv = 1'b0;
  endtask

  task automatic bus_start();
    cyc(2);
    sda_drv = 1'b1;
    scl_drv = 1'b1;
    cyc(8);
    sda_drv = 1'b0;
    cyc(8);
    scl_drv = 1'b0;
  endtask

  task automatic bus_stop();
    cyc(2);
    sda_drv = 1'b0;
    cyc(8);
    scl_drv = 1'b1;
    cyc(8);
    sda_drv = 1'b1;
    cyc(8);
  endtask

  task automatic byte_out(input logic [7:0] v);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(v[i]);
    get_bit(a);
    check({7'h0, a}, 8'h00);
  endtask

  task automatic reg_wr(input logic [4:0] idx, input logic [7:0] val);
    bus_start();
    byte_out({3'h0, idx});
    byte_out(val);
    bus_stop();
  endtask

  task automatic reg_rd(input logic [4:0] idx, output logic [7:0] v);
    bus_start();
    byte_out({3'h4, idx});
    for (int i = 7; i >= 0; i--) get_bit(v[i]);
    put_bit(1'b1);
    bus_stop();
  endtask

  task automatic rd_chk(input logic [4:0] idx, input logic [7:0] exp);
    logic [7:0] v;
    reg_rd(idx, v);
    check(v, exp);
  endtask

  task automatic set_in(input logic a, b, c, d, t);
    crx_lvl  = a ? 8'h40 : 8'hC0;
    ctx_lvl  = b ? 8'hC0 : 8'h40;
    tx_burst = c;
    rx_burst = d;
    tone     = t;
  endtask

  // waits for the attenuator pair to settle; sum must hold all the way
  task automatic wait_pos(input logic [7:0] tx_exp, input int limit, output int n);
    n = 0;
    while (!(diff_ctrl_tx_o === tx_exp && diff_ctrl_rx_o === 8'hFE - tx_exp) && n < limit) begin
      cyc(1);
      n++;
      check(8'(diff_ctrl_tx_o + diff_ctrl_rx_o), 8'hFE);
    end
    check(diff_ctrl_tx_o, tx_exp);
  endtask

  function automatic logic [1:0] exp_mode(input logic a, b, c, d, t);
    logic [1:0] m;
    if (a && b) m = c ? 2'd1 : 2'd0;
    else if (!a && !b) m = d ? 2'd2 : 2'd0;
    else m = (c || d) ? 2'd3 : 2'd0;
    if (m == 2'd0 && t) m = 2'd2;
    return m;
  endfunction

  // ==================================================================
  // scenarios
  task automatic t_reset();
    // outputs looked at while reset still holds
    check({6'h0, mode_o}, 8'h00);
    check({7'h0, four_point_o}, 8'h00);
    check(diff_ctrl_tx_o, 8'h7F);
    check(diff_ctrl_rx_o, 8'h7F);
    rst_n = 1'b1;
    cyc(4);
    // two-point after reset, quiet transmit side gives receive
    check({6'h0, mode_o}, 8'h02);
    rd_chk(5'h09, 8'h00);
    rd_chk(5'h0D, 8'h00);
    rd_chk(5'h0E, 8'h00);
    rd_chk(5'h0F, 8'h00);
  endtask

  task automatic t_regs();
    reg_wr(5'h0E, 8'hFF);
    rd_chk(5'h0E, 8'hFB);
    check({3'h0, rx_adj}, 8'h1F);
    reg_wr(5'h0F, 8'hFF);
    rd_chk(5'h0F, 8'hF8);
    check({3'h0, tx_adj}, 8'h1F);
    reg_wr(5'h0D, 8'hA5);
    rd_chk(5'h0D, 8'hA5);
    reg_wr(5'h05, 8'hFF);
    rd_chk(5'h05, 8'h00);
    reg_wr(5'h0E, 8'hA8);
    check({3'h0, rx_adj}, 8'h15);
    // mid-run reset clears every written register
    rst_n = 1'b0;
    cyc(2);
    check({3'h0, rx_adj}, 8'h00);
    check({3'h0, tx_adj}, 8'h00);
    rst_n = 1'b1;
    cyc(4);
    rd_chk(5'h0D, 8'h00);
    reg_wr(5'h0F, 8'h50);
    check({3'h0, tx_adj}, 8'h0A);
    reg_wr(5'h0E, 8'h00);
    reg_wr(5'h0F, 8'h00);
    check({3'h0, tx_adj}, 8'h00);
  endtask

  task automatic t_two_point();
    int n;
    tx_lvl = 8'hC0;
    cyc(6);
    check({6'h0, mode_o}, 8'h01);
    wait_pos(8'h00, 254 * FAST + 40, n);
    tx_lvl = 8'h40;
    cyc(6);
    check({6'h0, mode_o}, 8'h02);
    wait_pos(8'hFE, 254 * FAST + 40, n);
    check({7'h0, n >= 254 * FAST - 8}, 8'h01);
    tx_lvl = 8'h80;
  endtask

  task automatic t_decode();
    reg_wr(5'h09, 8'hFF);
    rd_chk(5'h09, 8'h7F);
    check({7'h0, four_point_o}, 8'h01);
    check({2'h0, afs_gain_o}, 8'h3F);
    for (int k = 0; k < 32; k++) begin
      set_in(k[4], k[3], k[2], k[1], k[0]);
      cyc(6);
      check({6'h0, mode_o}, {6'h0, exp_mode(k[4], k[3], k[2], k[1], k[0])});
    end
  endtask

  task automatic t_ramp();
    int n;
    set_in(1, 1, 1, 0, 0);
    wait_pos(8'h00, 254 * FAST + 40, n);
    rd_chk(5'h10, 8'h05);
    set_in(1, 0, 1, 0, 0);
    wait_pos(8'h7F, 127 * FAST + 40, n);
    check({7'h0, n >= 127 * FAST - 8}, 8'h01);
    set_in(1, 1, 1, 0, 0);
    wait_pos(8'h00, 127 * FAST + 40, n);
    set_in(1, 1, 0, 0, 0);
    cyc(6);
    check({6'h0, mode_o}, 8'h00);
    wait_pos(8'h7F, 127 * SLOW + 40, n);
    check({7'h0, n >= 127 * SLOW - 16}, 8'h01);
  endtask

  // ==================================================================
  // sequence and watchdog
  initial begin
    cyc(5);
    t_reset();
    t_regs();
    t_two_point();
    t_decode();
    t_ramp();
    final_report();
  end

  initial begin
    #300_000;
    fails++;
    final_report();
  end
endmodule
`default_nettype wire
